// ===== verilog/core_map.svh
// Constants for the instruction sequencer: codes, offsets, reset values.
// Included by the package, the core, the checker and the bench; holds definitions only.
`ifndef CORE_MAP_SVH
`define CORE_MAP_SVH
// Timing
`define CYC_CLKS 4
`define PHASE_LAST 2'(`CYC_CLKS - 1)
// Widths
`define PAW 11
`define DM_AW 5
`define STK_DEPTH 4
`define SP_W 2
// Opcodes, instruction word bits [15:11]
`define OP_MISC 5'h00
`define OP_ADD 5'h01
`define OP_SUB 5'h02
`define OP_LOGIC 5'h03
`define OP_INVERT 5'h04
`define OP_INC 5'h05
`define OP_MINUS 5'h06
`define OP_ROT 5'h07
`define OP_COPY_AM 5'h08
`define OP_COPY_MA 5'h09
`define OP_COPY_AI 5'h0A
`define OP_SET 5'h0B
`define OP_CLR 5'h0C
`define OP_JUMP 5'h0D
`define OP_CALL 5'h0E
`define OP_SKZ 5'h0F
`define OP_SKBZ 5'h10
`define OP_SKBNZ 5'h11
`define OP_TABRD 5'h12
// Miscellaneous sub-codes, instruction word bits [7:0]
`define MISC_SUB_EXIT 8'h01
`define MISC_INT_EXIT 8'h02
`define MISC_HALT 8'h03
// Data memory location aliased to the program counter low byte
`define DM_PC_LOW 5'h02
// Register offsets
`define REG_CTRL 8'h00
`define REG_STATUS 8'h04
`define REG_ACC 8'h08
`define REG_PC 8'h0C
// Field positions
`define CTRL_RUN 0
`define CTRL_WAKE 1
`define STAT_HALT 0
`define STAT_GIE 1
`define STAT_FLAGS 8
`define PCREG_TBLH 16
// Responses and reset values
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`define RST_RUN 1'b0
`endif

// ===== verilog/core_pkg.sv
// Types for the instruction sequencer: states, flags, whole core state.
// Assumes core_map.svh is on the include path.
package core_pkg;
`include "core_map.svh"
typedef enum logic [3:0] {
  ST_EXEC = 4'b0001,
  ST_FLUSH = 4'b0010,
  ST_TABLE = 4'b0100,
  ST_HALT = 4'b1000
} seq_t;

typedef struct packed {
  logic z;
  logic c;
  logic aux_c;
  logic ovf;
  logic spec_z;
  logic chain_z;
} flags_t;

typedef struct packed {
  seq_t seq;
  logic [1:0] phase;
  logic run;
  logic [`PAW-1:0] pc;
  logic [`PAW-1:0] pm_addr;
  logic [4:0] tbl_dst;
  logic [7:0] acc;
  logic [7:0] tblh;
  flags_t fl;
  logic gie;
  logic [(1<<`DM_AW)-1:0][7:0] dmem;
  logic [`STK_DEPTH-1:0][`PAW-1:0] stack;
  logic [`SP_W-1:0] sp;
  logic wake_meta;
  logic wake_sync;
  logic aw_hold;
  logic w_hold;
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic awready;
  logic wready;
  logic bvalid;
  logic [1:0] bresp;
  logic arready;
  logic rvalid;
  logic [31:0] rdata;
  logic [1:0] rresp;
} core_t;
endpackage

// ===== verilog/core_exec.sv
// 8-bit core sequencer: fetch, execute, extra cycles, AXI4-Lite control.
// Assumes a synchronous program ROM on aclk returning pm_data one clock
// after pm_addr changes; wake_pin is asynchronous.
`timescale 1ns/1ns
`include "core_map.svh"
module core_exec
  import core_pkg::*;
(
  // Clock, reset, enable
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  // AXI4-Lite write
  input wire logic awvalid,
  output logic awready,
  input wire logic [7:0] awaddr,
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  // AXI4-Lite read
  input wire logic arvalid,
  output logic arready,
  input wire logic [7:0] araddr,
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  // Program memory
  output logic [`PAW-1:0] pm_addr,
  input wire logic [15:0] pm_data,
  // Wake and power-down
  input wire logic wake_pin,
  output logic power_down
);
  localparam core_t CORE_RST = '{seq: ST_EXEC, run: `RST_RUN, default: '0};

  core_t r_ff;
  core_t nxt_r;

  always_comb begin
    logic wake_req;
    logic go;
    logic [4:0] op;
    logic [2:0] bidx;
    logic [7:0] m;
    logic [4:0] ma;
    logic [7:0] mval;
    logic [7:0] b;
    logic [7:0] res;
    logic [8:0] wide;
    logic [4:0] nib;
    logic cin;
    logic wr_m;
    logic wr_a;
    logic redirect;
    logic skip;
    logic [`PAW-1:0] pc_inc;
    logic [`PAW-1:0] pc_new;
    logic [31:0] rd;
    logic rd_ok;
    nxt_r = r_ff;
    wake_req = 1'b0;
    go = 1'b0;
    op = pm_data[15:11];
    bidx = pm_data[10:8];
    m = pm_data[7:0];
    ma = pm_data[4:0];
    mval = (ma == `DM_PC_LOW) ? r_ff.pc[7:0] : r_ff.dmem[ma];
    b = pm_data[9] ? m : mval;
    res = 8'h00;
    wide = 9'h000;
    nib = 5'h00;
    cin = 1'b0;
    wr_m = 1'b0;
    wr_a = 1'b0;
    redirect = 1'b0;
    skip = 1'b0;
    pc_inc = `PAW'(r_ff.pc + 1'b1);
    pc_new = pc_inc;
    rd = 32'h0000_0000;
    rd_ok = 1'b1;

    // Wake pin synchroniser
    nxt_r.wake_meta = wake_pin;
    nxt_r.wake_sync = r_ff.wake_meta;

    // Write address and data, taken in either order
    if (awvalid && r_ff.awready) begin
      nxt_r.aw_hold = 1'b1;
      nxt_r.aw_addr = awaddr;
    end
    if (wvalid && r_ff.wready) begin
      nxt_r.w_hold = 1'b1;
      nxt_r.w_data = wdata;
      nxt_r.w_strb = wstrb;
    end
    if (r_ff.bvalid && bready) begin
      nxt_r.bvalid = 1'b0;
    end
    if (r_ff.aw_hold && r_ff.w_hold && !r_ff.bvalid) begin
      nxt_r.aw_hold = 1'b0;
      nxt_r.w_hold = 1'b0;
      nxt_r.bvalid = 1'b1;
      nxt_r.bresp = `RESP_OKAY;
      unique case (r_ff.aw_addr)
        `REG_CTRL: begin
          if (r_ff.w_strb[0]) begin
            nxt_r.run = r_ff.w_data[`CTRL_RUN];
            wake_req = r_ff.w_data[`CTRL_WAKE];
          end
        end
        `REG_STATUS, `REG_ACC, `REG_PC: ;
        default: nxt_r.bresp = `RESP_SLVERR;
      endcase
    end
    nxt_r.awready = !nxt_r.aw_hold;
    nxt_r.wready = !nxt_r.w_hold;

    // Read channel
    unique case (araddr)
      `REG_CTRL: rd[`CTRL_RUN] = r_ff.run;
      `REG_STATUS: begin
        rd[`STAT_HALT] = r_ff.seq == ST_HALT;
        rd[`STAT_GIE] = r_ff.gie;
        rd[`STAT_FLAGS +: 6] = r_ff.fl;
      end
      `REG_ACC: rd[7:0] = r_ff.acc;
      `REG_PC: begin
        rd[`PAW-1:0] = r_ff.pc;
        rd[`PCREG_TBLH +: 8] = r_ff.tblh;
      end
      default: rd_ok = 1'b0;
    endcase
    if (r_ff.rvalid && rready) begin
      nxt_r.rvalid = 1'b0;
    end
    if (arvalid && r_ff.arready) begin
      nxt_r.rvalid = 1'b1;
      nxt_r.rdata = rd;
      nxt_r.rresp = rd_ok ? `RESP_OKAY : `RESP_SLVERR;
    end
    nxt_r.arready = !nxt_r.rvalid;

    // Instruction cycle of four phases
    if (r_ff.run && r_ff.seq != ST_HALT) begin
      nxt_r.phase = 2'(r_ff.phase + 2'h1);
      go = r_ff.phase == `PHASE_LAST;
    end

    unique case (r_ff.seq)
      ST_EXEC: begin
        if (go) begin
          unique case (op)
            `OP_ADD: begin
              cin = pm_data[8] & r_ff.fl.c;
              wide = {1'b0, r_ff.acc} + {1'b0, b} + {8'h00, cin};
              nib = {1'b0, r_ff.acc[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
              res = wide[7:0];
              nxt_r.fl.c = wide[8];
              nxt_r.fl.aux_c = nib[4];
              nxt_r.fl.ovf = (r_ff.acc[7] == b[7]) && (res[7] != b[7]);
              nxt_r.fl.z = res == 8'h00;
              nxt_r.fl.spec_z = res[7] ^ nxt_r.fl.ovf;
              wr_m = pm_data[10];
              wr_a = !pm_data[10];
            end
            `OP_SUB: begin
              cin = pm_data[8] & r_ff.fl.c;
              wide = {1'b0, r_ff.acc} - {1'b0, b} - {8'h00, cin};
              nib = {1'b0, r_ff.acc[3:0]} - {1'b0, b[3:0]} - {4'h0, cin};
              res = wide[7:0];
              nxt_r.fl.c = wide[8];
              nxt_r.fl.aux_c = nib[4];
              nxt_r.fl.ovf = (r_ff.acc[7] != b[7]) && (res[7] != r_ff.acc[7]);
              nxt_r.fl.z = res == 8'h00;
              nxt_r.fl.spec_z = res[7] ^ nxt_r.fl.ovf;
              // Chained zero carries zero through multi-byte borrows
              nxt_r.fl.chain_z = (res == 8'h00) &
                (!pm_data[8] | r_ff.fl.chain_z);
              wr_m = pm_data[10];
              wr_a = !pm_data[10];
            end
            `OP_LOGIC: begin
              unique case (pm_data[9:8])
                2'h0: res = r_ff.acc & (pm_data[10] ? m : mval);
                2'h1: res = r_ff.acc | (pm_data[10] ? m : mval);
                2'h2: res = r_ff.acc ^ (pm_data[10] ? m : mval);
                2'h3: res = r_ff.acc;
              endcase
              nxt_r.fl.z = res == 8'h00;
              wr_a = 1'b1;
            end
            `OP_INVERT: begin
              res = ~mval;
              nxt_r.fl.z = res == 8'h00;
              wr_m = !pm_data[10];
              wr_a = pm_data[10];
            end
            `OP_INC, `OP_MINUS: begin
              res = (op == `OP_INC) ? 8'(mval + 8'h01) : 8'(mval - 8'h01);
              nxt_r.fl.z = res == 8'h00;
              wr_m = !pm_data[10];
              wr_a = pm_data[10];
            end
            `OP_ROT: begin
              cin = pm_data[9] ? r_ff.fl.c : (pm_data[8] ? mval[7] : mval[0]);
              res = pm_data[8] ? {mval[6:0], cin} : {cin, mval[7:1]};
              if (pm_data[9]) begin
                nxt_r.fl.c = pm_data[8] ? mval[7] : mval[0];
              end
              wr_m = !pm_data[10];
              wr_a = pm_data[10];
            end
            `OP_COPY_AM: begin
              res = mval;
              wr_a = 1'b1;
            end
            `OP_COPY_MA: begin
              res = r_ff.acc;
              wr_m = 1'b1;
            end
            `OP_COPY_AI: begin
              res = m;
              wr_a = 1'b1;
            end
            `OP_SET: begin
              res = mval | 8'(8'h01 << bidx);
              wr_m = 1'b1;
            end
            `OP_CLR: begin
              res = mval & ~8'(8'h01 << bidx);
              wr_m = 1'b1;
            end
            `OP_JUMP: begin
              pc_new = pm_data[`PAW-1:0];
              redirect = 1'b1;
            end
            `OP_CALL: begin
              nxt_r.stack[r_ff.sp] = pc_inc;
              nxt_r.sp = `SP_W'(r_ff.sp + 1'b1);
              pc_new = pm_data[`PAW-1:0];
              redirect = 1'b1;
            end
            `OP_SKZ: begin
              if (pm_data[9]) begin
                res = mval;
                wr_a = 1'b1;
              end
              skip = (mval == 8'h00) ^ pm_data[8];
            end
            `OP_SKBZ: skip = !mval[bidx];
            `OP_SKBNZ: skip = mval[bidx];
            `OP_TABRD: begin
              nxt_r.pm_addr = {{(`PAW-8){1'b0}}, r_ff.acc};
              nxt_r.tbl_dst = ma;
              nxt_r.seq = ST_TABLE;
            end
            `OP_MISC: begin
              if (m == `MISC_SUB_EXIT || m == `MISC_INT_EXIT) begin
                nxt_r.sp = `SP_W'(r_ff.sp - 1'b1);
                pc_new = r_ff.stack[nxt_r.sp];
                redirect = 1'b1;
                if (m == `MISC_INT_EXIT) begin
                  nxt_r.gie = 1'b1;
                end
              end
              if (m == `MISC_HALT) begin
                nxt_r.seq = ST_HALT;
              end
            end
            default: ;
          endcase
          if (wr_a) begin
            nxt_r.acc = res;
          end
          if (wr_m && ma == `DM_PC_LOW) begin
            pc_new = {pc_inc[`PAW-1:8], res};
            redirect = 1'b1;
          end else if (wr_m) begin
            nxt_r.dmem[ma] = res;
          end
          if (skip) begin
            pc_new = `PAW'(r_ff.pc + 2'h2);
          end
          nxt_r.pc = pc_new;
          if (nxt_r.seq != ST_TABLE) begin
            nxt_r.pm_addr = pc_new;
          end
          if (redirect || skip) begin
            nxt_r.seq = ST_FLUSH;
          end
        end
      end
      ST_FLUSH: begin
        // Prefetched word is discarded; nothing executes
        if (go) begin
          nxt_r.seq = ST_EXEC;
        end
      end
      ST_TABLE: begin
        if (go) begin
          if (r_ff.tbl_dst == `DM_PC_LOW) begin
            nxt_r.pc = {r_ff.pc[`PAW-1:8], pm_data[7:0]};
          end else begin
            nxt_r.dmem[r_ff.tbl_dst] = pm_data[7:0];
          end
          nxt_r.tblh = pm_data[15:8];
          nxt_r.pm_addr = nxt_r.pc;
          nxt_r.seq = ST_EXEC;
        end
      end
      ST_HALT: begin
        nxt_r.phase = 2'h0;
        if (wake_req || r_ff.wake_sync) begin
          nxt_r.seq = ST_EXEC;
        end
      end
      default: nxt_r.seq = ST_EXEC;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      r_ff <= CORE_RST;
    end else if (ce) begin
      r_ff <= nxt_r;
    end
  end

  assign awready = r_ff.awready;
  assign wready = r_ff.wready;
  assign bvalid = r_ff.bvalid;
  assign bresp = r_ff.bresp;
  assign arready = r_ff.arready;
  assign rvalid = r_ff.rvalid;
  assign rdata = r_ff.rdata;
  assign rresp = r_ff.rresp;
  assign pm_addr = r_ff.pm_addr;
  assign power_down = r_ff.seq[3];
endmodule

// ===== testbench/core_exec_asserts.sv
// Checker for core_exec: bus handshakes, cycle pacing, power-down.
// Assumes it is bound to core_exec, with one clock and ce held high.
`timescale 1ns/1ns
`include "core_map.svh"
module core_exec_asserts (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite
  input wire logic awvalid,
  input wire logic awready,
  input wire logic wvalid,
  input wire logic wready,
  input wire logic bvalid,
  input wire logic bready,
  input wire logic [1:0] bresp,
  input wire logic arvalid,
  input wire logic arready,
  input wire logic [7:0] araddr,
  input wire logic rvalid,
  input wire logic rready,
  input wire logic [31:0] rdata,
  input wire logic [1:0] rresp,
  // Core
  input wire logic [`PAW-1:0] pm_addr,
  input wire logic wake_pin,
  input wire logic power_down
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_cycle_four: assert property ($changed(pm_addr) |=> $stable(pm_addr)[*3])
    else $error("program address moved inside a cycle");
  a_halt_sticks: assert property (power_down && awready && !awvalid &&
    !bvalid && !wake_pin && !$past(wake_pin) && !$past(wake_pin, 2)
    |=> power_down) else $error("left power-down without a wake");
  a_halt_idle: assert property (power_down && $past(power_down)
    |-> $stable(pm_addr)) else $error("fetching while powered down");
  a_read_answer: assert property (arvalid && arready |=> rvalid)
    else $error("read not answered");
  a_read_holds: assert property (rvalid && !rready
    |=> rvalid && $stable(rdata) && $stable(rresp))
    else $error("read answer dropped early");
  a_read_unmapped: assert property (arvalid && arready && araddr > 8'h0C
    |=> rresp == `RESP_SLVERR && rdata == 32'h0)
    else $error("unmapped read not refused");
  a_write_answer: assert property (awvalid && awready && wvalid && wready
    |-> ##[2:4] bvalid) else $error("write not answered");
  a_write_holds: assert property (bvalid && !bready
    |=> bvalid && $stable(bresp)) else $error("write answer dropped early");
  c_halt: cover property ($rose(power_down));
  c_wake: cover property ($fell(power_down) && wake_pin);
  c_slverr: cover property (bvalid && bready && bresp == `RESP_SLVERR);
endmodule

bind core_exec core_exec_asserts core_exec_asserts_i (.aclk, .aresetn,
  .awvalid, .awready, .wvalid, .wready, .bvalid, .bready, .bresp, .arvalid,
  .arready, .araddr, .rvalid, .rready, .rdata, .rresp, .pm_addr, .wake_pin,
  .power_down);

// ===== testbench/testbench.sv
// Self-checking bench for core_exec: registers, programs, cycle counts.
// Assumes core_map.svh on the include path; the bench acts as the ROM.
`timescale 1ns/1ns
`include "core_map.svh"
module testbench;
  logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, wake_pin, power_down;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, q;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;
  logic [`PAW-1:0] pm_addr;
  logic [15:0] pm_data;
  logic [15:0] rom [0:(1<<`PAW)-1];
  int fails, compares, busy, mark, base;

  core_exec core_exec_i (.aclk, .aresetn, .ce(1'b1), .awvalid, .awready,
    .awaddr, .wvalid, .wready, .wdata, .wstrb, .bvalid, .bready, .bresp,
    .arvalid, .arready, .araddr, .rvalid, .rready, .rdata, .rresp,
    .pm_addr, .pm_data, .wake_pin, .power_down);

  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end

  always @(posedge aclk) begin
    pm_data <= rom[pm_addr];
    if (power_down === 1'b0)
      busy <= busy + 1;
  end

  task wrap_up;
    if (fails == 0 && compares > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task lost;
    fails++;
    wrap_up;
  endtask

  task wr(input [7:0] a, input [31:0] d, input [3:0] s, input [1:0] er);
    int i;
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    for (i = 0; i < 100; i++) begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid && bready) break;
      // Late ready makes the slave hold its answer for a cycle
      if (bvalid) bready <= 1'b1;
    end
    if (i == 100) lost;
    chk(32'(bresp), 32'(er));
    bready <= 1'b0;
    @(posedge aclk);
  endtask

  task rd(input [7:0] a, input [1:0] er);
    int i;
    araddr <= a;
    arvalid <= 1'b1;
    for (i = 0; i < 100; i++) begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
      if (rvalid && rready) break;
      if (rvalid) rready <= 1'b1;
    end
    if (i == 100) lost;
    q = rdata;
    chk(32'(rresp), 32'(er));
    rready <= 1'b0;
    @(posedge aclk);
  endtask

  task pd(input logic v);
    int i;
    for (i = 0; i < 2000 && power_down !== v; i++)
      @(posedge aclk);
    if (i == 2000) lost;
  endtask

  task p(input int a, input [4:0] op, input int md, input [7:0] m);
    rom[a] = {op, md[2:0], m};
  endtask

  // Wait for halt, judge ACC, flags, enable and run length, then wake
  task ck(input [7:0] a, input [5:0] f, input g, input int n);
    int len;
    pd(1'b1);
    len = busy - mark;
    mark = busy;
    if (n == 1) base = len;
    if (n > 0) chk(len, base + 4 * (n - 1));
    rd(`REG_ACC, `RESP_OKAY);
    chk(32'(q[7:0]), 32'(a));
    rd(`REG_STATUS, `RESP_OKAY);
    chk(32'({q[13:8], q[1:0]}), 32'({f, g, 1'b1}));
    wr(`REG_CTRL, 32'h3, 4'hF, `RESP_OKAY);
  endtask

  task load_rom;
    foreach (rom[i]) rom[i] = {`OP_MISC, 3'h0, `MISC_HALT};
    p(0, `OP_COPY_AI, 0, 8'hF0);
    p(1, `OP_COPY_MA, 0, 8'h05);
    p(2, `OP_ADD, 2, 8'h20);
    p(5, `OP_SUB, 2, 8'h10);
    p(7, `OP_COPY_AI, 0, 8'h5A);
    p(8, `OP_ADD, 2, 8'h00);
    p(9, `OP_LOGIC, 6, 8'h5A);
    p(11, `OP_INC, 0, 8'h05);
    p(12, `OP_MINUS, 4, 8'h05);
    p(13, `OP_SUB, 2, 8'hF1);
    p(15, `OP_ROT, 6, 8'h05);
    p(17, `OP_ROT, 1, 8'h05);
    p(18, `OP_COPY_AM, 0, 8'h05);
    p(20, `OP_SET, 3, 8'h05);
    p(21, `OP_CLR, 7, 8'h05);
    p(22, `OP_COPY_AM, 0, 8'h05);
    p(24, `OP_CALL, 0, 8'h40);
    p(64, `OP_COPY_AI, 0, 8'h33);
    p(65, `OP_MISC, 0, `MISC_SUB_EXIT);
    p(26, `OP_COPY_AI, 0, 8'h00);
    p(27, `OP_COPY_MA, 0, 8'h06);
    p(28, `OP_SKZ, 0, 8'h06);
    p(29, `OP_COPY_AI, 0, 8'h11);
    p(30, `OP_COPY_AI, 0, 8'h22);
    p(31, `OP_SKBNZ, 0, 8'h05);
    p(32, `OP_COPY_AI, 0, 8'h44);
    p(33, `OP_SKBZ, 0, 8'h05);
    p(34, `OP_ADD, 2, 8'h01);
    p(36, `OP_COPY_AI, 0, 8'h50);
    p(37, `OP_COPY_MA, 0, {3'h0, `DM_PC_LOW});
    p(38, `OP_COPY_AI, 0, 8'h99);
    p(81, `OP_JUMP, 0, 8'h60);
    p(96, `OP_CALL, 0, 8'h68);
    p(104, `OP_COPY_AI, 0, 8'h70);
    p(105, `OP_TABRD, 0, 8'h07);
    p(106, `OP_COPY_AM, 0, 8'h07);
    p(107, `OP_MISC, 0, `MISC_INT_EXIT);
    rom[112] = 16'hA5C3;
  endtask

  task t_regs;
    rd(`REG_CTRL, `RESP_OKAY);
    chk(q, 32'h0);
    rd(`REG_STATUS, `RESP_OKAY);
    chk(q, 32'h0);
    rd(`REG_PC, `RESP_OKAY);
    chk(q, 32'h0);
    rd(8'h10, `RESP_SLVERR);
    chk(q, 32'h0);
    wr(8'h20, 32'h1, 4'hF, `RESP_SLVERR);
    wr(`REG_ACC, 32'hFF, 4'hF, `RESP_OKAY);
    rd(`REG_ACC, `RESP_OKAY);
    chk(q, 32'h0);
    wr(`REG_CTRL, 32'h1, 4'h0, `RESP_OKAY);
    rd(`REG_CTRL, `RESP_OKAY);
    chk(q, 32'h0);
    chk(32'(pm_addr), 32'h0);
  endtask

  task t_alu;
    wr(`REG_CTRL, 32'h1, 4'hF, `RESP_OKAY);
    ck(8'h10, 6'b010000, 1'b0, 0);
    ck(8'h10, 6'b010000, 1'b0, 1);
    ck(8'h00, 6'b100001, 1'b0, 2);
    ck(8'h00, 6'b100001, 1'b0, 4);
    ck(8'hFF, 6'b011010, 1'b0, 4);
    ck(8'hF8, 6'b011010, 1'b0, 2);
    ck(8'hE3, 6'b011010, 1'b0, 3);
    ck(8'h6B, 6'b011010, 1'b0, 4);
  endtask

  task t_flow;
    ck(8'h33, 6'b011010, 1'b0, 6);
    ck(8'h23, 6'b000000, 1'b0, 10);
    ck(8'h50, 6'b000000, 1'b0, 4);
    ck(8'hC3, 6'b000000, 1'b1, 11);
    rd(`REG_PC, `RESP_OKAY);
    chk(32'(q[23:16]), 32'hA5);
    ck(8'hC3, 6'b000000, 1'b1, 1);
  endtask

  task t_pin;
    wake_pin <= 1'b1;
    pd(1'b0);
    wake_pin <= 1'b0;
    pd(1'b1);
    rd(`REG_STATUS, `RESP_OKAY);
    chk(32'(q[0]), 32'h1);
  endtask

  initial begin
    {awvalid, wvalid, bready, arvalid, rready, wake_pin} = 6'h00;
    awaddr = 8'h00;
    araddr = 8'h00;
    wdata = 32'h0;
    wstrb = 4'h0;
    aresetn = 1'b0;
    pm_data = 16'h0000;
    {fails, compares, busy, mark, base} = '0;
    load_rom;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_regs;
    t_alu;
    t_flow;
    t_pin;
    wrap_up;
  end
endmodule
